// File: hw/plc_pkg.sv
/*
  Constants and carrier types for the PLL lock and sleep clock controller.
  Assumes a single 20 MHz system clock and a synchronous active-high reset.
*/
// Functional notes
// R01: Main PLL off after reset until enabled
// R02: Crystal change refreshes read-only PLL translation
// R03: Same crystal value rewrite causes no relock
// R04: PLL power-up starts a relock interval
// R05: Lock counter on main oscillator, load 0x1200
// R06: Crystal above 0x0f loads 0x2400 instead
// R07: Main PLL not system clock before lock
// R08: Combined enable-and-select waits, then switches
// R09: Main PLL lock raw flag, maskable interrupt
// R10: USB PLL ungated; lock flag and interrupt
// R11: USB PLL off after reset, on when cleared
// R12: USB PLL referenced only to main oscillator
// R13: Powered-down PLL does not drive output
// R14: Oscillator monitor only when enabled, flags band
// R15: Fault: cause bit, internal osc, 32-period reset
// R16: After fault reset, steer processor to NMI
// R17: Run mode gates peripherals by run registers
// R18: Sleep: core off, sleep or run gating
// R19: Deep sleep: core off, deep or run gating
// R20: Deep sleep uses main osc unless internal chosen
// R21: Deep sleep powers PLL down, divider /16 or /64
// R22: Restore clock before re-enabling gated clocks on exit
// R23: Counter steps per oscillator tick, flag at zero
// R24: Extended override fields take precedence
// R25: Internal oscillator is source after reset
package plc_pkg;
  localparam int          CRYSTAL_SELECT_W        = 5;            // Crystal select width
  localparam int          DIV_W         = 6;            // System divider width
  localparam int          CNT_W         = 14;           // Lock counter width
  localparam int          GATE_W        = 32;           // Peripherals per gating word
  localparam logic [13:0] LOCK_LOAD_LO  = 14'h1200;     // Normal lock count
  localparam logic [13:0] LOCK_LOAD_HI  = 14'h2400;     // High-crystal lock count
  localparam logic [4:0]  CRYSTAL_SELECT_HI_LIMIT = 5'h0F;        // Above this, long count
  localparam logic [4:0]  CRYSTAL_SELECT_RST      = 5'h0B;        // Crystal select at reset
  localparam logic [5:0]  DSLP_DIV_STD  = 6'h0F;        // /16 for first config
  localparam logic [5:0]  DSLP_DIV_EXT  = 6'h3F;        // /64 for extended config
  localparam logic [5:0]  FAULT_RST_LEN = 6'h20;        // 32 internal osc periods
  localparam logic [5:0]  MON_MIN       = 6'h03;        // About 1 MHz over a 63-cycle window
  localparam logic [5:0]  MON_MAX       = 6'h34;        // About 16.4 MHz; above that is a fault
  localparam logic [7:0]  MON_WINDOW    = 8'h3F;        // Monitor window in clk cycles

  // Clock source codes
  typedef enum logic [1:0] {
    SRC_MAIN = 2'b00, SRC_INT = 2'b01, SRC_INT4 = 2'b10, SRC_SLOW = 2'b11
  } plc_src_e;

  // Power mode of the core
  typedef enum logic [1:0] {
    MODE_RUN = 2'b00, MODE_SLEEP = 2'b01, MODE_DEEP = 2'b10
  } plc_mode_e;

  // One clock configuration register image
  typedef struct packed {
    logic [4:0] crystal_select;       // Crystal select
    plc_src_e   oscSrc;     // Oscillator source
    logic       pllPwrDown; // Main PLL power-down
    logic       bypass;     // Bypass PLL
    logic [5:0] system_divider;     // System divider
    logic       useSysDiv;  // Apply divider
    logic       autoGate;   // Automatic gating in sleep modes
  } plc_cfg_s;

  // Effective clock selection toward the clock tree
  typedef struct packed {
    plc_src_e   src;        // Raw source
    logic       usePll;     // PLL output selected
    logic       useDiv;     // Divider in use
    logic [5:0] div;        // Divider value
  } plc_clksel_s;
endpackage

// File: hw/plc_clock_ctrl.sv
/*
  PLL lock timing, system clock selection, oscillator fault handling and
  per-mode peripheral clock gating for the system controller.
  Assumes all inputs, including the main oscillator tick, are synchronous
  to clk; the tick marks one main oscillator period.
*/
`timescale 1ns/100ps
module plc_clock_ctrl
  import plc_pkg::*;
#(
  parameter int GATE_WORDS = 3 // Gating registers per mode
) (
  // Clock and reset
  input  wire logic                          clk,
  input  wire logic                          sys_rst,
  // Configuration from software
  input  wire plc_cfg_s                      runCfg,
  input  wire plc_cfg_s                      extCfg,
  input  wire logic                          extConfigOverride,
  input  wire logic                          usbPllPowerDown,
  input  wire logic                          oscMonitorEnable,
  input  wire logic                          dsUseInternal,
  input  wire plc_src_e                      dsSrc,
  input  wire logic                          pllLockIrqMask,
  input  wire logic                          usbLockIrqMask,
  input  wire logic                          lockFlagClear,
  input  wire logic                          causeClear,
  input  wire logic [GATE_W*GATE_WORDS-1:0]  runGating,
  input  wire logic [GATE_W*GATE_WORDS-1:0]  sleepGating,
  input  wire logic [GATE_W*GATE_WORDS-1:0]  deepGating,
  // Core power state and oscillator tick
  input  wire logic                          sleepReq,
  input  wire logic                          deepReq,
  input  wire logic                          wakeIrq,
  input  wire logic                          mainOscTick,
  // Status and control outputs
  output plc_cfg_s                           activeCfg,
  output logic [CRYSTAL_SELECT_W-1:0]                  crystalPllTranslation,
  output logic                               mainPllLockRaw,
  output logic                               usbPllLockRaw,
  output logic                               pllLockIrq,
  output logic                               mainPllRun,
  output logic                               usbPllRun,
  output logic                               usbPllRefMain,
  output plc_clksel_s                        clkSel,
  output logic                               internalOscOn,
  output logic                               mainOscOn,
  output logic                               oscFaultCause,
  output logic                               sysResetOut,
  output logic                               nmiReq,
  output logic                               coreClkEn,
  output logic [GATE_W*GATE_WORDS-1:0]       periphClkEn,
  output plc_mode_e                          powerMode
);
  // Effective configuration with override (R24)
  plc_cfg_s  cfgEff;
  assign cfgEff = extConfigOverride ? extCfg : runCfg; // R24

  logic [CRYSTAL_SELECT_W-1:0] xtalPrev_q;     // Last crystal select seen
  logic              pllPdPrev_q;    // Last main PLL power-down seen
  logic              usbPdPrev_q;    // Last USB PLL power-down seen
  logic [CNT_W-1:0]  lockCnt_q;      // Main PLL lock down counter
  logic [CNT_W-1:0]  usbCnt_q;       // USB PLL lock down counter
  logic              relock;         // Main relock trigger
  logic              usbRelock;      // USB relock trigger
  logic [CNT_W-1:0]  loadVal;        // Count chosen for crystal
  logic              pllLocked;      // Main lock elapsed
  plc_mode_e         mode_q;         // Current power mode
  plc_clksel_s       saved_q;        // Selection frozen at deep-sleep entry
  logic              dsPllDown_q;    // PLL forced down by deep sleep
  logic [5:0]        faultCnt_q;     // Fault reset length counter
  logic [7:0]        monWin_q;       // Monitor window timer
  logic [5:0]        monTicks_q;     // Osc ticks in window
  logic              monBad;         // Window ended out of band
  logic              restoring_q;    // One cycle of clock restore before gates

  // Relock only on real change; same value rewrites are ignored
  assign relock    = (cfgEff.crystal_select != xtalPrev_q) || // R02 R03
                     (pllPdPrev_q && !cfgEff.pllPwrDown); // R04
  assign usbRelock = (cfgEff.crystal_select != xtalPrev_q) || (usbPdPrev_q && !usbPllPowerDown);
  assign loadVal   = (cfgEff.crystal_select > CRYSTAL_SELECT_HI_LIMIT) ? LOCK_LOAD_HI : LOCK_LOAD_LO; // R05 R06
  assign pllLocked = (lockCnt_q == '0);

  // Change trackers; reset values match the reset configuration
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      xtalPrev_q  <= CRYSTAL_SELECT_RST;
      pllPdPrev_q <= 1'b1;
      usbPdPrev_q <= 1'b1;
    end else begin
      xtalPrev_q  <= cfgEff.crystal_select;
      pllPdPrev_q <= cfgEff.pllPwrDown;
      usbPdPrev_q <= usbPllPowerDown;
    end
  end

  // Translation register follows the crystal select
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      crystalPllTranslation <= CRYSTAL_SELECT_RST;
    end else if (cfgEff.crystal_select != xtalPrev_q) begin
      crystalPllTranslation <= cfgEff.crystal_select; // R02
    end
  end

  // Lock counters step once per oscillator tick
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      lockCnt_q <= LOCK_LOAD_LO;
      usbCnt_q  <= LOCK_LOAD_LO;
    end else begin
      if (relock) begin
        lockCnt_q <= loadVal; // R05 R06
      end else if (mainOscTick && lockCnt_q != '0) begin
        lockCnt_q <= lockCnt_q - 1'b1; // R23
      end
      if (usbRelock) begin
        usbCnt_q <= loadVal;
      end else if (mainOscTick && usbCnt_q != '0) begin
        usbCnt_q <= usbCnt_q - 1'b1; // R23
      end
    end
  end

  // Raw lock flags: a lock event wins over a same-cycle clear
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mainPllLockRaw <= 1'b0;
      usbPllLockRaw  <= 1'b0;
      pllLockIrq     <= 1'b0;
    end else begin
      if (lockCnt_q == 14'h0001 && mainOscTick && !relock) begin
        mainPllLockRaw <= 1'b1; // R09 R23
      end else if (relock || lockFlagClear) begin
        mainPllLockRaw <= 1'b0; // R23
      end
      if (usbCnt_q == 14'h0001 && mainOscTick && !usbRelock) begin
        usbPllLockRaw <= 1'b1; // R10
      end else if (usbRelock || lockFlagClear) begin
        usbPllLockRaw <= 1'b0;
      end
      pllLockIrq <= (mainPllLockRaw && pllLockIrqMask) ||
                    (usbPllLockRaw && usbLockIrqMask); // R09 R10
    end
  end

  // Oscillator monitor: counts ticks per fixed window when enabled
  assign monBad = (monWin_q == MON_WINDOW) &&
                  (monTicks_q < MON_MIN || monTicks_q > MON_MAX);
  always_ff @(posedge clk) begin
    if (sys_rst || !oscMonitorEnable) begin
      monWin_q   <= '0; // R14
      monTicks_q <= '0;
    end else if (monWin_q == MON_WINDOW) begin
      monWin_q   <= '0;
      monTicks_q <= '0;
    end else begin
      monWin_q   <= monWin_q + 1'b1;
      if (mainOscTick && monTicks_q != 6'h3F) begin
        monTicks_q <= monTicks_q + 1'b1;
      end
    end
  end

  // Fault sequence; the cause bit survives the reset it produces
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      faultCnt_q    <= '0;
      sysResetOut   <= 1'b0;
      nmiReq        <= 1'b0;
      oscFaultCause <= 1'b0;
    end else begin
      if (monBad) begin
        oscFaultCause <= 1'b1; // R15
      end else if (causeClear) begin
        oscFaultCause <= 1'b0;
      end
      if (monBad && faultCnt_q == '0) begin
        faultCnt_q  <= FAULT_RST_LEN; // R15
        sysResetOut <= 1'b1;
      end else if (faultCnt_q != '0) begin
        faultCnt_q  <= faultCnt_q - 1'b1;
        sysResetOut <= (faultCnt_q != 6'h01);
      end
      nmiReq <= sysResetOut && faultCnt_q == 6'h01; // R16
    end
  end

  // Power mode; any enabled interrupt returns to run
  always_ff @(posedge clk) begin
    if (sys_rst || sysResetOut) begin
      mode_q      <= MODE_RUN;
      restoring_q <= 1'b0;
    end else begin
      restoring_q <= 1'b0;
      case (mode_q)
        MODE_RUN: begin
          if (deepReq) begin
            mode_q <= MODE_DEEP;
          end else if (sleepReq) begin
            mode_q <= MODE_SLEEP;
          end
        end
        MODE_SLEEP: begin
          if (wakeIrq) begin
            mode_q <= MODE_RUN;
          end
        end
        MODE_DEEP: begin
          if (wakeIrq) begin
            mode_q      <= MODE_RUN; // R22
            restoring_q <= 1'b1;
          end
        end
        default: mode_q <= MODE_RUN;
      endcase
    end
  end

  // Deep-sleep entry snapshot of the clock selection
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      saved_q     <= '{src: SRC_INT, usePll: 1'b0, useDiv: 1'b0, div: '0};
      dsPllDown_q <= 1'b0;
    end else if (mode_q == MODE_RUN && deepReq) begin
      saved_q     <= clkSel;
      dsPllDown_q <= mainPllRun; // R21
    end else if (mode_q != MODE_DEEP) begin
      dsPllDown_q <= 1'b0;
    end
  end

  // Clock selection, PLL power and oscillator enables
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      clkSel        <= '{src: SRC_INT, usePll: 1'b0, useDiv: 1'b0, div: '0}; // R25
      mainPllRun    <= 1'b0; // R01
      usbPllRun     <= 1'b0; // R11
      usbPllRefMain <= 1'b1; // R12
      internalOscOn <= 1'b1; // R25
      mainOscOn     <= 1'b0;
    end else if (monBad || sysResetOut) begin
      internalOscOn <= 1'b1; // R15
      clkSel.src    <= SRC_INT;
      clkSel.usePll <= 1'b0;
      mainPllRun    <= 1'b0;
    end else if (mode_q == MODE_DEEP) begin
      clkSel.src    <= dsUseInternal ? dsSrc : SRC_MAIN; // R20
      internalOscOn <= dsUseInternal;
      mainOscOn     <= !dsUseInternal;
      clkSel.usePll <= 1'b0;
      mainPllRun    <= 1'b0; // R21
      if (dsPllDown_q) begin
        clkSel.div <= extConfigOverride ? DSLP_DIV_EXT : DSLP_DIV_STD; // R21
      end
    end else if (restoring_q) begin
      clkSel <= saved_q; // R22
    end else begin
      // Sleep keeps the run source and frequency
      mainPllRun    <= !cfgEff.pllPwrDown; // R01 R13
      usbPllRun     <= !usbPllPowerDown; // R11 R13
      mainOscOn     <= 1'b1;
      internalOscOn <= 1'b1;
      clkSel.src    <= cfgEff.oscSrc; // R18
      clkSel.useDiv <= cfgEff.useSysDiv;
      clkSel.div    <= cfgEff.system_divider;
      clkSel.usePll <= !cfgEff.bypass && !cfgEff.pllPwrDown && pllLocked && !relock; // R07 R08
    end
  end

  // Core clock and peripheral gating per mode
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      coreClkEn   <= 1'b1;
      periphClkEn <= '0;
    end else begin
      case (mode_q)
        MODE_RUN: begin
          // Core and peripherals wait one cycle while the clock is restored
          if (!restoring_q) begin
            coreClkEn   <= 1'b1; // R17 R22
            periphClkEn <= runGating; // R17 R22
          end
        end
        MODE_SLEEP: begin
          coreClkEn   <= 1'b0; // R18
          periphClkEn <= cfgEff.autoGate ? sleepGating : runGating; // R18
        end
        MODE_DEEP: begin
          coreClkEn   <= 1'b0; // R19
          periphClkEn <= cfgEff.autoGate ? deepGating : runGating; // R19
        end
        default: begin
          coreClkEn   <= 1'b1;
          periphClkEn <= runGating;
        end
      endcase
    end
  end

  // Registered copies of mode and effective configuration
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      powerMode <= MODE_RUN;
      activeCfg <= '0;
    end else begin
      powerMode <= mode_q;
      activeCfg <= cfgEff;
    end
  end
endmodule

// File: testbench/plc_ctrl_assertions.sv
/*
  Port-level checker for the clock controller.
  Assumes one clk domain, synchronous sys_rst, bound from the bench.
*/
`timescale 1ns/100ps
module plc_ctrl_assertions
  import plc_pkg::*;
#(
  parameter int GATE_WORDS = 3 // Gating registers per mode
) (
  // Clock and reset
  input wire logic                         clk,
  input wire logic                         sys_rst,
  // Watched inputs
  input wire logic                         usbPllPowerDown,
  input wire logic                         pllLockIrqMask,
  input wire logic [GATE_W*GATE_WORDS-1:0] runGating,
  // Watched outputs
  input wire logic                         mainPllLockRaw,
  input wire logic                         pllLockIrq,
  input wire logic                         mainPllRun,
  input wire logic                         usbPllRun,
  input wire logic                         usbPllRefMain,
  input wire plc_clksel_s                  clkSel,
  input wire logic                         internalOscOn,
  input wire logic                         oscFaultCause,
  input wire logic                         sysResetOut,
  input wire logic                         nmiReq,
  input wire logic                         coreClkEn,
  input wire logic [GATE_W*GATE_WORDS-1:0] periphClkEn,
  input wire plc_mode_e                    powerMode
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic [6:0] rstLen_q; // Cycles the fault reset has stood
  // Length counter; a repetition of 32 would be too costly
  always_ff @(posedge clk) begin
    if (sys_rst || !sysResetOut)
      rstLen_q <= 7'h00;
    else
      rstLen_q <= rstLen_q + 7'h01;
  end
  // Fault reset steps
  sequence faultStart;
    $rose(sysResetOut);
  endsequence
  sequence faultEnd;
    $fell(sysResetOut);
  endsequence
  chk_reset_state: assert property (
    $fell(sys_rst) |-> clkSel.src == SRC_INT && !clkSel.usePll && !mainPllRun && !usbPllRun)
    else $error("Clock state wrong after reset");
  chk_usb_off: assert property (
    usbPllPowerDown |=> !usbPllRun) else $error("USB PLL runs while powered down");
  chk_usb_ref: assert property (
    usbPllRefMain) else $error("USB PLL reference not main oscillator");
  chk_lock_gate: assert property (
    $rose(clkSel.usePll) && powerMode == MODE_RUN && $past(powerMode, 2) == MODE_RUN
    |-> $past(mainPllLockRaw)) else $error("PLL selected before lock");
  chk_irq_follow: assert property (
    $rose(mainPllLockRaw) && pllLockIrqMask |=> pllLockIrq) else $error("Lock irq missing");
  chk_fault_entry: assert property (
    faultStart |=> oscFaultCause && internalOscOn && clkSel.src == SRC_INT)
    else $error("Fault entry steps wrong");
  chk_fault_length: assert property (
    faultEnd |-> rstLen_q == 7'h20) else $error("Fault reset length wrong");
  chk_nmi_after: assert property (
    faultEnd |-> ##[0:1] nmiReq) else $error("No NMI after fault reset");
  chk_core_stop: assert property (
    powerMode != MODE_RUN && $past(powerMode) != MODE_RUN |-> !coreClkEn)
    else $error("Core clocked in sleep");
  chk_run_gates: assert property (
    !$past(sys_rst) && powerMode == MODE_RUN && $past(powerMode) == MODE_RUN &&
    $past(powerMode, 2) == MODE_RUN
    |-> periphClkEn == $past(runGating)) else $error("Run gating mismatch");
endmodule

// File: testbench/pll_lock_and_sleep_clock_ctrl_tb.sv
/*
  Self-checking bench for plc_clock_ctrl; drives every port itself.
  Assumes the checker module is compiled before this file.
*/
`timescale 1ns/100ps
module pll_lock_and_sleep_clock_ctrl_tb;
  import plc_pkg::*;
  localparam int GW = 3;           // Gating words per mode
  localparam int GB = GATE_W * GW; // Gating bits per mode
  logic          clk, sys_rst, ovr, usbDown, monEn, dsInt, irqMask, flagClr, causeClr, uMask;
  logic          slpReq, dpReq, wake, tick, mRaw, uRaw, irq, mRun, uRun, uRef;
  logic          iOn, mOn, cause, rstOut, nmi, core, got;
  logic [4:0]    trans;
  logic [GB-1:0] runG, slpG, dpG, pEn;
  logic [31:0]   r;
  logic [31:0]   seed = 32'hDDBB43F8;                     // Xorshift state
  logic [3:0]    modes [5] = '{4'h4, 4'h0, 4'hC, 4'hE, 4'h9}; // Deep, auto, override, internal
  plc_cfg_s      cfg, act, ext;                           // Run image and override image
  plc_clksel_s   sel;
  plc_mode_e     mode;
  plc_src_e      dsSrc;
  int            errorCnt, checks, n;

  // Override image differs only in the divider, so selection is visible
  assign ext = {cfg.crystal_select, cfg.oscSrc, cfg.pllPwrDown, cfg.bypass, ~cfg.system_divider, cfg.useSysDiv,
                cfg.autoGate};

  plc_clock_ctrl #(.GATE_WORDS(GW)) u_dut (
    .clk, .sys_rst, .runCfg(cfg), .extCfg(ext), .extConfigOverride(ovr),
    .usbPllPowerDown(usbDown), .oscMonitorEnable(monEn), .dsUseInternal(dsInt), .dsSrc,
    .pllLockIrqMask(irqMask), .usbLockIrqMask(uMask), .lockFlagClear(flagClr),
    .causeClear(causeClr), .runGating(runG), .sleepGating(slpG), .deepGating(dpG),
    .sleepReq(slpReq), .deepReq(dpReq), .wakeIrq(wake), .mainOscTick(tick),
    .activeCfg(act), .crystalPllTranslation(trans), .mainPllLockRaw(mRaw),
    .usbPllLockRaw(uRaw), .pllLockIrq(irq), .mainPllRun(mRun), .usbPllRun(uRun),
    .usbPllRefMain(uRef), .clkSel(sel), .internalOscOn(iOn), .mainOscOn(mOn),
    .oscFaultCause(cause), .sysResetOut(rstOut), .nmiReq(nmi), .coreClkEn(core),
    .periphClkEn(pEn), .powerMode(mode)
  );

  // Free-running 20 MHz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Inputs change 2 ns after the edge, outputs are settled by then
  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #2;
  endtask

  task automatic check(input logic [GB-1:0] seen, input logic [GB-1:0] exp);
    checks++;
    if (seen !== exp) begin
      errorCnt++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("Checks %0d, errors %0d", checks, errorCnt);
    if (errorCnt == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Enable and select the PLL in one write, then time the lock
  task automatic relock(input logic [4:0] x, input logic m);
    int k;
    int ld;
    k = 0;
    ld = (x > 5'h0F) ? 32'h2400 : 32'h1200; // Expected lock count
    irqMask = m;
    cfg.crystal_select = x;
    cfg.pllPwrDown = 1'b0;
    cfg.bypass = 1'b0;
    cfg.oscSrc = SRC_MAIN;
    step(1);
    while (mRaw !== 1'b1 && k < 20000) begin
      if (k > 2) check(sel.usePll, 1'b0);
      step(1);
      k++;
    end
    if (mRaw !== 1'b1) begin
      errorCnt++;
      conclude();
    end
    check(k >= ld - 1 && k <= ld + 3, 1'b1);
    check({trans, sel.src}, {x, SRC_MAIN});
    step(2);
    check({sel.usePll, irq, mRun}, {1'b1, m, 1'b1});
  endtask

  // Enter sleep or deep sleep, look, then wake and look again
  task automatic lowPower(input logic dp, input logic ag, input logic ov, input logic di);
    plc_clksel_s saved;
    cfg.autoGate = ag;
    ovr = ov;
    dsInt = di;
    step(2);
    check(act, ov ? ext : cfg);
    saved = sel;
    dpReq = dp;
    slpReq = !dp;
    step(1);
    {dpReq, slpReq} = 2'b00;
    step(4);
    check({mode, core}, {dp ? MODE_DEEP : MODE_SLEEP, 1'b0});
    check(pEn, !ag ? runG : (dp ? dpG : slpG));
    if (!dp) check(sel, saved);
    else begin
      check({sel.src, mOn}, {di ? SRC_INT : SRC_MAIN, !di});
      check({sel.usePll, mRun, sel.div}, {2'b00, ov ? 6'h3F : 6'h0F});
    end
    wake = 1'b1;
    step(1);
    wake = 1'b0;
    step(4);
    check(sel, saved);
    check({core, pEn}, {1'b1, runG});
  endtask

  initial begin
    {errorCnt, checks} = 0;
    {sys_rst, usbDown, tick} = 3'b111;
    {ovr, monEn, dsInt, irqMask, flagClr, causeClr, slpReq, dpReq, wake, uMask} = 10'h000;
    dsSrc = SRC_INT;
    cfg = '0;
    cfg.crystal_select = 5'h0B;
    cfg.oscSrc = SRC_INT;
    {cfg.pllPwrDown, cfg.bypass} = 2'b11;
    {runG, slpG, dpG} = {rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd()};
    step(12);
    sys_rst = 1'b0;
    step(2);
    check({sel.src, sel.usePll, mRun, uRun, mRaw, uRaw, uRef, trans},
          {SRC_INT, 6'b000001, 5'h0B});
    relock(5'h0F, 1'b1);
    relock(5'h10, 1'b0);
    flagClr = 1'b1;
    step(1);
    flagClr = 1'b0;
    cfg.crystal_select = 5'h10; // Same crystal written again
    step(300);
    check({mRaw, sel.usePll}, 2'b01);
    cfg.pllPwrDown = 1'b1;
    step(3);
    check({mRun, uRun}, 2'b00);
    usbDown = 1'b0;
    step(3);
    check(uRun, 1'b1);
    relock(5'h10, 1'b1); // Power-up alone relocks
    check(uRaw, 1'b1);
    {irqMask, uMask} = 2'b01;
    step(2);
    check(irq, 1'b1);
    uMask = 1'b0;
    r = rnd();
    relock({1'b0, r[3:0]}, 1'b1);
    foreach (modes[i]) lowPower(modes[i][3], modes[i][2], modes[i][1], modes[i][0]);
    tick = 1'b0;
    step(200);
    check(cause, 1'b0);
    monEn = 1'b1;
    n = 0;
    while (rstOut !== 1'b1 && n < 300) begin
      step(1);
      n++;
    end
    if (rstOut !== 1'b1) begin
      errorCnt++;
      conclude();
    end
    check({cause, sel.src, iOn}, {1'b1, SRC_INT, 1'b1});
    n = 0;
    got = 1'b0;
    while (rstOut === 1'b1 && n < 100) begin
      step(1);
      n++;
      got = got | nmi;
    end
    if (rstOut === 1'b1) begin
      errorCnt++;
      conclude();
    end
    check(n, 32);
    step(1);
    check(got | nmi, 1'b1);
    conclude();
  end
endmodule

bind plc_clock_ctrl plc_ctrl_assertions #(.GATE_WORDS(GATE_WORDS)) u_chk (
  .clk, .sys_rst, .usbPllPowerDown, .pllLockIrqMask, .runGating, .mainPllLockRaw,
  .pllLockIrq, .mainPllRun, .usbPllRun, .usbPllRefMain, .clkSel, .internalOscOn,
  .oscFaultCause, .sysResetOut, .nmiReq, .coreClkEn, .periphClkEn, .powerMode
);
